// ==== design/fpc_latch_mem.sv ====
// Column latch page buffer: 128 bytes, one write port, registered read
module fpc_latch_mem (
  input  wire logic       clk,
  input  wire logic       ce,
  input  wire logic       wr_en,
  input  wire logic [6:0] wr_idx,
  input  wire logic [7:0] wr_data,
  input  wire logic [6:0] rd_idx,
  output logic      [7:0] rd_data
);

  // Storage array; contents are undefined until loaded, which is fine
  // because only bytes marked loaded are ever programmed
  logic [7:0] mem_q [128];

  // Write port
  always_ff @(posedge clk) begin
    if (ce && wr_en) begin
      mem_q[wr_idx] <= wr_data;
    end
  end

  // Registered read port
  always_ff @(posedge clk) begin
    if (ce) begin
      rd_data <= mem_q[rd_idx];
    end
  end

endmodule

// ==== design/fpc_pkg.sv ====
// Shared constants and types for the flash program control block
package fpc_pkg;

  // Flash control register location in the special-function space
  localparam logic [7:0] FPC_CTRL_ADDR     = 8'hd1;
  localparam logic [7:0] FPC_CTRL_RESET    = 8'h00;

  // Flash control field positions
  localparam int         FPC_NIB_MSB       = 7;
  localparam int         FPC_NIB_LSB       = 4;
  localparam int         FPC_MAP_BIT       = 3;
  localparam int         FPC_SPC_MSB       = 2;
  localparam int         FPC_SPC_LSB       = 1;
  localparam int         FPC_BUSY_BIT      = 0;

  // Launch codes written into the upper nibble
  localparam logic [3:0] FPC_CODE_ARM      = 4'h5;
  localparam logic [3:0] FPC_CODE_GO       = 4'ha;

  // Space select codes
  localparam logic [1:0] FPC_SPC_USER      = 2'h0;
  localparam logic [1:0] FPC_SPC_XROW      = 2'h1;
  localparam logic [1:0] FPC_SPC_SEC       = 2'h2;
  localparam logic [1:0] FPC_SPC_RSVD      = 2'h3;

  // Array geometry
  localparam int         FPC_PAGE_BYTES    = 128;
  localparam int         FPC_PAGES         = 256;
  localparam int         FPC_IDX_W         = 7;
  localparam int         FPC_PAGE_W        = 8;
  localparam logic [15:0] FPC_XROW_BASE    = 16'hff80;
  localparam logic [15:0] FPC_SEC_ADDR     = 16'h0000;
  localparam logic [15:0] FPC_ARRAY_TOP    = 16'h7fff;

  // Security byte field positions
  localparam int         FPC_SPEED_BIT     = 7;
  localparam int         FPC_BOOT_BIT      = 6;
  localparam int         FPC_OSC_MSB       = 5;
  localparam int         FPC_OSC_LSB       = 4;
  localparam int         FPC_LB2_BIT       = 2;
  localparam int         FPC_LB1_BIT       = 1;
  localparam int         FPC_LB0_BIT       = 0;

  // Factory default of the security byte: standard speed, loader boot,
  // 32 MHz range, all three lock bits programmed (level 4)
  localparam logic [7:0] FPC_SEC_DEFAULT   = 8'hb8;

  // Reset start addresses
  localparam logic [15:0] FPC_BOOT_APP     = 16'h0000;
  localparam logic [15:0] FPC_BOOT_LOADER  = 16'hf400;

  // Oscillator range codes
  localparam logic [1:0] FPC_OSC_32        = 2'h3;
  localparam logic [1:0] FPC_OSC_16        = 2'h2;
  localparam logic [1:0] FPC_OSC_8         = 2'h1;
  localparam logic [1:0] FPC_OSC_BAD       = 2'h0;

  // Erase-and-program time and its cycle count at 25 MHz
  localparam int         FPC_CLK_HZ        = 25_000_000;
  localparam int         FPC_PROG_MS       = 10;
  localparam int         FPC_PROG_CYCLES   = FPC_PROG_MS * (FPC_CLK_HZ / 1000);

  // Sequencer states
  typedef enum logic [1:0] {
    FPC_IDLE,
    FPC_ERASE,
    FPC_WRITE,
    FPC_WAIT
  } fpc_state_t;

endpackage

// ==== design/fpc_top.sv ====
// Flash program control and security configuration for the CPU core
// Behaviour
// [R1] Launch needs nibble 5 then A
// [R2] Map bit maps latches into data space
// [R3] Space select: user, extra row, security; 11 idle
// [R4] Busy flag set when programming starts
// [R5] Hardware clears busy; software cannot
// [R6] Control register resets to zero
// [R7] 256 pages of 128 bytes addressing
// [R8] Programming erases loaded bytes first
// [R9] Busy held for 10 ms
// [R10] CPU held idle while busy
// [R11] Speed bit clear selects six-clock mode
// [R12] Boot bit picks 0000h or F400h
// [R13] Boot bit defaults clear: loader
// [R14] Oscillator field picks range; one forbidden
// [R15] Osc 11=32, 10=16, 01=8, 00 forbidden
// [R16] Lock bit one means unprogrammed
// [R17] No lock programmed: level 1
// [R18] Level 2 blocks external table reads, latches pin
// [R19] Level 3 blocks parallel verify
// [R20] Level 4 blocks external execution
// [R21] Pin low: fetch from external memory
// [R22] Arm lost if next write lacks A
module fpc_top #(
  parameter int PROG_CYCLES = fpc_pkg::FPC_PROG_CYCLES
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        ce,
  input  wire logic [7:0]  sfr_addr,
  input  wire logic        sfr_wr,
  input  wire logic [7:0]  sfr_wdata,
  output logic      [7:0]  sfr_rdata,
  input  wire logic        xdata_wr,
  input  wire logic [15:0] xdata_addr,
  input  wire logic [7:0]  xdata_wdata,
  input  wire logic [7:0]  nv_sec_in,
  input  wire logic        ext_access_pin,
  input  wire logic        code_table_read_from_ext,
  output logic             latch_mapped,
  output logic [1:0]       code_space,
  output logic             cpu_idle_req,
  output logic             arr_erase,
  output logic             arr_write,
  output logic [15:0]      arr_addr,
  output logic [7:0]       arr_wdata,
  output logic             double_speed_mode,
  output logic [15:0]      boot_addr,
  output logic [1:0]       osc_range,
  output logic             osc_forbidden,
  output logic [2:0]       security_level,
  output logic             table_read_block,
  output logic             parallel_prog_disable,
  output logic             parallel_verify_disable,
  output logic             external_exec_disable,
  output logic             internal_code_enable
);

  // Flash control register fields
  logic [3:0]  nibble_q;      // Last written launch nibble (read back)
  logic        map_q;         // Latch map select
  logic [1:0]  space_q;       // Space select
  logic        busy_q;        // Programming busy flag
  logic        armed_q;       // First launch code seen
  logic [1:0]  prog_space_q;  // Space captured at launch

  // Column latch bookkeeping
  logic [127:0] loaded_q;     // One flag per latch byte
  logic [7:0]   page_q;       // Page of the last latch write
  logic [6:0]   walk_q;       // Byte index walked by sequencer
  logic [6:0]   walk_d1_q;    // Index matching the memory read data
  logic         walk_v_q;     // Read data valid this cycle
  logic [7:0]   lat_rdata;    // Registered latch read data

  // Timing and security state
  fpc_pkg::fpc_state_t state_q;
  logic [31:0]  tmr_q;        // Busy hold timer
  logic [7:0]   sec_q;        // Working copy of the security byte
  logic         ea_s1_q;      // Pin synchroniser, first stage
  logic         ea_s2_q;      // Pin synchroniser, second stage
  logic         ea_latched_q; // Pin value caught after reset release
  logic         init_q;       // One-shot load after reset
  logic [2:0]   level;        // Decoded security level

  // Decoded events
  logic ctrl_wr;
  logic go;
  logic lat_wr;

  assign ctrl_wr = sfr_wr && (sfr_addr == fpc_pkg::FPC_CTRL_ADDR);
  // Launch: armed, go code, legal space, not already busy
  assign go      = ctrl_wr && armed_q && !busy_q &&
                   (sfr_wdata[fpc_pkg::FPC_NIB_MSB:fpc_pkg::FPC_NIB_LSB] == fpc_pkg::FPC_CODE_GO)
                   && (sfr_wdata[fpc_pkg::FPC_SPC_MSB:fpc_pkg::FPC_SPC_LSB]
                       != fpc_pkg::FPC_SPC_RSVD); // [R1] [R3]
  // Latch load only while mapped and not programming, so the buffer
  // cannot change under the sequencer
  assign lat_wr  = xdata_wr && map_q && !busy_q; // [R2]

  // Security level from lock bits; zero means programmed
  function automatic logic [2:0] lock_level(input logic [7:0] sec);
    if (!sec[fpc_pkg::FPC_LB2_BIT]) begin
      lock_level = 3'h4; // [R20]
    end else if (!sec[fpc_pkg::FPC_LB1_BIT]) begin
      lock_level = 3'h3; // [R19]
    end else if (!sec[fpc_pkg::FPC_LB0_BIT]) begin
      lock_level = 3'h2; // [R18]
    end else begin
      lock_level = 3'h1; // [R16] [R17]
    end
  endfunction

  assign level = lock_level(sec_q);

  // Page buffer storage
  fpc_latch_mem u_mem (
    .clk     (clk),
    .ce      (ce),
    .wr_en   (lat_wr),
    .wr_idx  (xdata_addr[fpc_pkg::FPC_IDX_W-1:0]),
    .wr_data (xdata_wdata),
    .rd_idx  (walk_q),
    .rd_data (lat_rdata)
  );

  // Control register: software-writable fields; busy is not among them
  always_ff @(posedge clk) begin
    if (rst) begin
      nibble_q <= fpc_pkg::FPC_CTRL_RESET[7:4]; // [R6]
      map_q    <= fpc_pkg::FPC_CTRL_RESET[3];
      space_q  <= fpc_pkg::FPC_CTRL_RESET[2:1];
    end else if (ce && ctrl_wr) begin
      nibble_q <= sfr_wdata[fpc_pkg::FPC_NIB_MSB:fpc_pkg::FPC_NIB_LSB];
      map_q    <= sfr_wdata[fpc_pkg::FPC_MAP_BIT]; // [R2]
      space_q  <= sfr_wdata[fpc_pkg::FPC_SPC_MSB:fpc_pkg::FPC_SPC_LSB]; // [R3]
    end
  end

  // Unlock arming: only the very next control write can complete it
  always_ff @(posedge clk) begin
    if (rst) begin
      armed_q <= 1'b0;
    end else if (ce && ctrl_wr) begin
      armed_q <= (sfr_wdata[fpc_pkg::FPC_NIB_MSB:fpc_pkg::FPC_NIB_LSB]
                  == fpc_pkg::FPC_CODE_ARM); // [R1] [R22]
    end
  end

  // Latch load flags and page address; last write picks the page
  always_ff @(posedge clk) begin
    if (rst) begin
      loaded_q <= '0;
      page_q   <= '0;
    end else if (ce) begin
      if (lat_wr) begin
        loaded_q[xdata_addr[fpc_pkg::FPC_IDX_W-1:0]] <= 1'b1;
        page_q <= xdata_addr[14:7]; // [R7]
      end else if (state_q == fpc_pkg::FPC_WAIT && tmr_q == 32'h0) begin
        loaded_q <= '0; // Buffer consumed by the operation
      end
    end
  end

  // Sequencer: erase pass, write pass, then hold out the full time
  always_ff @(posedge clk) begin
    if (rst) begin
      state_q      <= fpc_pkg::FPC_IDLE;
      busy_q       <= 1'b0;
      walk_q       <= '0;
      tmr_q        <= '0;
      prog_space_q <= fpc_pkg::FPC_SPC_USER;
    end else if (ce) begin
      unique case (state_q)
        fpc_pkg::FPC_IDLE: begin
          if (go) begin
            busy_q       <= 1'b1; // [R4]
            prog_space_q <= sfr_wdata[fpc_pkg::FPC_SPC_MSB:fpc_pkg::FPC_SPC_LSB];
            walk_q       <= '0;
            tmr_q        <= 32'(PROG_CYCLES - 1); // [R9]
            state_q      <= fpc_pkg::FPC_ERASE;
          end
        end
        fpc_pkg::FPC_ERASE: begin
          tmr_q  <= tmr_q - 32'h1;
          walk_q <= walk_q + 7'h1;
          if (walk_q == 7'h7f) begin
            state_q <= fpc_pkg::FPC_WRITE; // [R8]
          end
        end
        fpc_pkg::FPC_WRITE: begin
          tmr_q  <= tmr_q - 32'h1;
          walk_q <= walk_q + 7'h1;
          if (walk_q == 7'h7f) begin
            state_q <= fpc_pkg::FPC_WAIT;
          end
        end
        fpc_pkg::FPC_WAIT: begin
          if (tmr_q == 32'h0) begin
            busy_q  <= 1'b0; // [R5]
            state_q <= fpc_pkg::FPC_IDLE;
          end else begin
            tmr_q <= tmr_q - 32'h1; // [R9]
          end
        end
      endcase
    end
  end

  // Read data lags the walk index by one cycle through the memory
  always_ff @(posedge clk) begin
    if (rst) begin
      walk_d1_q <= '0;
      walk_v_q  <= 1'b0;
    end else if (ce) begin
      walk_d1_q <= walk_q;
      walk_v_q  <= (state_q == fpc_pkg::FPC_WRITE);
    end
  end

  // Array strobes: erase then program only the bytes that were loaded
  always_ff @(posedge clk) begin
    if (rst) begin
      arr_erase <= 1'b0;
      arr_write <= 1'b0;
      arr_addr  <= '0;
      arr_wdata <= '0;
    end else if (ce) begin
      arr_erase <= (state_q == fpc_pkg::FPC_ERASE) && loaded_q[walk_q] &&
                   (prog_space_q != fpc_pkg::FPC_SPC_SEC); // [R8]
      arr_write <= walk_v_q && loaded_q[walk_d1_q] &&
                   (prog_space_q != fpc_pkg::FPC_SPC_SEC);
      arr_wdata <= lat_rdata;
      unique case (prog_space_q)
        fpc_pkg::FPC_SPC_XROW: begin
          arr_addr <= fpc_pkg::FPC_XROW_BASE | {9'h0, (walk_v_q ? walk_d1_q : walk_q)};
        end
        fpc_pkg::FPC_SPC_SEC: begin
          arr_addr <= fpc_pkg::FPC_SEC_ADDR;
        end
        default: begin
          arr_addr <= {1'b0, page_q, (walk_v_q ? walk_d1_q : walk_q)}; // [R7]
        end
      endcase
    end
  end

  // Security byte: default, then the stored value after reset; the
  // upper four bits take a programmed latch byte 0, the locks stay
  always_ff @(posedge clk) begin
    if (rst) begin
      sec_q  <= fpc_pkg::FPC_SEC_DEFAULT; // [R11] [R13]
      init_q <= 1'b1;
    end else if (ce) begin
      if (init_q) begin
        sec_q  <= nv_sec_in;
        init_q <= 1'b0;
      end else if (walk_v_q && walk_d1_q == 7'h00 && loaded_q[0] &&
                   prog_space_q == fpc_pkg::FPC_SPC_SEC) begin
        sec_q[7:4] <= lat_rdata[7:4];
      end
    end
  end

  // External access pin synchroniser; it keeps running through reset
  // so the one-shot catch below sees the real pin, not a reset zero
  always_ff @(posedge clk) begin
    if (ce) begin
      ea_s1_q <= ext_access_pin;
      ea_s2_q <= ea_s1_q;
    end
  end

  // Pin value caught once, at the first enabled edge after reset
  always_ff @(posedge clk) begin
    if (rst) begin
      ea_latched_q <= 1'b0;
    end else if (ce && init_q) begin
      ea_latched_q <= ea_s2_q; // [R18]
    end
  end

  // Registered outputs: mapping, idle request and readback
  always_ff @(posedge clk) begin
    if (rst) begin
      latch_mapped <= 1'b0;
      code_space   <= fpc_pkg::FPC_SPC_USER;
      cpu_idle_req <= 1'b0;
      sfr_rdata    <= fpc_pkg::FPC_CTRL_RESET;
    end else if (ce) begin
      latch_mapped <= map_q; // [R2]
      code_space   <= space_q; // [R3]
      cpu_idle_req <= busy_q || go; // [R10]
      sfr_rdata    <= (sfr_addr == fpc_pkg::FPC_CTRL_ADDR) ?
                      {nibble_q, map_q, space_q, busy_q} : 8'h00;
    end
  end

  // Registered outputs: configuration decoded from the security byte
  always_ff @(posedge clk) begin
    if (rst) begin
      double_speed_mode       <= 1'b0;
      boot_addr               <= fpc_pkg::FPC_BOOT_LOADER;
      osc_range               <= fpc_pkg::FPC_OSC_32;
      osc_forbidden           <= 1'b0;
      security_level          <= 3'h4;
      table_read_block        <= 1'b0;
      parallel_prog_disable   <= 1'b1;
      parallel_verify_disable <= 1'b1;
      external_exec_disable   <= 1'b1;
      internal_code_enable    <= 1'b0;
    end else if (ce) begin
      double_speed_mode <= !sec_q[fpc_pkg::FPC_SPEED_BIT]; // [R11]
      boot_addr         <= sec_q[fpc_pkg::FPC_BOOT_BIT] ?
                           fpc_pkg::FPC_BOOT_APP : fpc_pkg::FPC_BOOT_LOADER; // [R12]
      osc_range         <= sec_q[fpc_pkg::FPC_OSC_MSB:fpc_pkg::FPC_OSC_LSB]; // [R14]
      osc_forbidden     <= (sec_q[fpc_pkg::FPC_OSC_MSB:fpc_pkg::FPC_OSC_LSB]
                            == fpc_pkg::FPC_OSC_BAD); // [R15]
      security_level    <= level;
      table_read_block  <= (level >= 3'h2) && code_table_read_from_ext; // [R18]
      parallel_prog_disable   <= (level >= 3'h2); // [R18]
      parallel_verify_disable <= (level >= 3'h3); // [R19]
      external_exec_disable   <= (level >= 3'h4); // [R20]
      internal_code_enable    <= (level >= 3'h2) ? ea_latched_q : ea_s2_q; // [R21]
    end
  end

endmodule

// ==== test/fpc_cpu_model.sv ====
// CPU core model driving special-function and data-space writes
module fpc_cpu_model (
  input  wire logic        clk,
  input  wire logic [7:0]  sfr_rdata,
  output logic      [7:0]  sfr_addr,
  output logic             sfr_wr,
  output logic      [7:0]  sfr_wdata,
  output logic             xdata_wr,
  output logic      [15:0] xdata_addr,
  output logic      [7:0]  xdata_wdata
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle bus at time zero
  initial begin
    sfr_addr = 8'h00;
    sfr_wr = 1'b0;
    sfr_wdata = 8'h00;
    xdata_wr = 1'b0;
    xdata_addr = 16'h0000;
    xdata_wdata = 8'h00;
  end

  // One-cycle write; released data is inverted so no stale value lingers
  task sfr_write(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    sfr_addr <= a;
    sfr_wr <= 1'b1;
    sfr_wdata <= d;
    @(posedge clk);
    sfr_wr <= 1'b0;
    sfr_wdata <= ~d;
    sfr_addr <= 8'h00;
  endtask

  // Registered read: data settles one cycle after the address
  task sfr_read(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    sfr_addr <= a;
    @(posedge clk);
    #1;
    d = sfr_rdata;
  endtask

  // Latch load: low bits pick the byte, upper bits the page
  task xdata_write(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    xdata_addr <= a;
    xdata_wr <= 1'b1;
    xdata_wdata <= d;
    @(posedge clk);
    xdata_wr <= 1'b0;
    xdata_wdata <= ~d;
  endtask
endmodule

// ==== test/fpc_top_properties.sv ====
// Checker for the flash program control block, port level only
module fpc_top_properties #(
  parameter int PROG_CYCLES = 300
) (
  input wire logic       clk,
  input wire logic       rst,
  input wire logic [7:0] sfr_addr,
  input wire logic       sfr_wr,
  input wire logic [7:0] sfr_wdata,
  input wire logic       code_table_read_from_ext,
  input wire logic       cpu_idle_req,
  input wire logic       arr_erase,
  input wire logic       arr_write,
  input wire logic [1:0] osc_range,
  input wire logic       osc_forbidden,
  input wire logic [2:0] security_level,
  input wire logic       table_read_block,
  input wire logic       parallel_prog_disable,
  input wire logic       parallel_verify_disable,
  input wire logic       external_exec_disable
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  logic [19:0] idle_cnt_q;  // Cycles the CPU has been held idle
  logic        go_wr;       // Control write carrying the second launch code

  // Launch write seen on the register bus
  assign go_wr = sfr_wr && (sfr_addr == 8'hd1) && (sfr_wdata[7:4] == 4'ha);

  // Count idle cycles; cleared whenever the hold drops
  always_ff @(posedge clk) begin
    if (rst || !cpu_idle_req) begin
      idle_cnt_q <= 20'h0;
    end else begin
      idle_cnt_q <= idle_cnt_q + 20'h1;
    end
  end

  AST_LAUNCH_CAUSE: assert property ($rose(cpu_idle_req) |->
    $past(go_wr, 1) || $past(go_wr, 2))
    else $error("idle hold began without a launch write");
  AST_IDLE_MIN: assert property ($rose(cpu_idle_req) |-> cpu_idle_req[*8])
    else $error("idle hold too short");
  AST_BUSY_LEN: assert property ($fell(cpu_idle_req) |->
    idle_cnt_q >= PROG_CYCLES && idle_cnt_q <= PROG_CYCLES + 3)
    else $error("busy period length wrong");
  AST_STROBE_BUSY: assert property ((arr_erase || arr_write) |-> cpu_idle_req)
    else $error("array strobe outside busy");
  AST_PASS_EXCL: assert property (!(arr_erase && arr_write))
    else $error("erase and write strobes together");
  AST_LEVEL_RANGE: assert property (security_level inside {3'h1, 3'h2, 3'h3, 3'h4})
    else $error("security level out of range");
  AST_OSC_BAD: assert property ($stable(osc_range) |->
    osc_forbidden == (osc_range == 2'h0))
    else $error("forbidden oscillator flag wrong");
  AST_PROG_DIS: assert property ($stable(security_level) |->
    parallel_prog_disable == (security_level >= 3'h2))
    else $error("parallel program disable wrong");
  AST_VERIFY_DIS: assert property ($stable(security_level) |->
    parallel_verify_disable == (security_level >= 3'h3))
    else $error("parallel verify disable wrong");
  AST_EXEC_DIS: assert property ($stable(security_level) |->
    external_exec_disable == (security_level == 3'h4))
    else $error("external execution disable wrong");
  AST_TABLE_BLK: assert property ($stable(security_level) |->
    table_read_block == ($past(code_table_read_from_ext) && security_level >= 3'h2))
    else $error("table read block wrong");

  // Main scenarios reached
  COV_LAUNCH: cover property ($rose(cpu_idle_req));
  COV_WRITE: cover property (arr_write);
  COV_TBLOCK: cover property (table_read_block);
endmodule

// ==== test/tb.sv ====
// Self-checking bench for the flash program control block
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int         PROG_CYCLES = 300;  // Short busy time keeps the run brief
  localparam logic [7:0] CTRL = fpc_pkg::FPC_CTRL_ADDR;
  localparam logic [7:0] SEC_TBL [5] = '{8'hf7, 8'h26, 8'h15, 8'h08, 8'hb8};
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  nv_sec = 8'hf7;  // Stored security byte
  logic        pin = 1'b1;      // External access pin
  logic        code_table_read = 1'b0;     // Table read issued from external code
  logic [7:0]  sfr_addr, sfr_wdata, sfr_rdata, xdata_wdata, arr_wdata, rd, last_wd;
  logic [15:0] xdata_addr, arr_addr, boot_addr, last_wa;
  logic [1:0]  code_space, osc_range;
  logic [2:0]  security_level;
  logic        sfr_wr, xdata_wr, latch_mapped, cpu_idle_req, arr_erase, arr_write;
  logic        dsm, osc_bad, trb, ppd, pvd, eed, ice;
  int          errors = 0, checked = 0, cyc = 0, n_er = 0, n_wr = 0, n;

  always #20 clk = ~clk;

  fpc_top #(.PROG_CYCLES(PROG_CYCLES)) uut (.clk(clk), .rst(rst), .ce(1'b1),
    .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
    .xdata_wr(xdata_wr), .xdata_addr(xdata_addr), .xdata_wdata(xdata_wdata),
    .nv_sec_in(nv_sec), .ext_access_pin(pin), .code_table_read_from_ext(code_table_read),
    .latch_mapped(latch_mapped), .code_space(code_space), .cpu_idle_req(cpu_idle_req),
    .arr_erase(arr_erase), .arr_write(arr_write), .arr_addr(arr_addr),
    .arr_wdata(arr_wdata), .double_speed_mode(dsm), .boot_addr(boot_addr),
    .osc_range(osc_range), .osc_forbidden(osc_bad), .security_level(security_level),
    .table_read_block(trb), .parallel_prog_disable(ppd), .parallel_verify_disable(pvd),
    .external_exec_disable(eed), .internal_code_enable(ice));

  fpc_cpu_model cpu (.clk(clk), .sfr_rdata(sfr_rdata), .sfr_addr(sfr_addr),
    .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata), .xdata_wr(xdata_wr),
    .xdata_addr(xdata_addr), .xdata_wdata(xdata_wdata));

  // Strobe monitor and hang guard
  always @(posedge clk) begin
    cyc++;
    if (arr_erase === 1'b1) n_er++;
    if (arr_write === 1'b1) begin
      n_wr++;
      last_wa = arr_addr;
      last_wd = arr_wdata;
    end
    if (cyc == 20000) begin
      errors++;
      tally_and_finish();
    end
  end

  task chk(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // Reset with a given stored byte and pin level; held six cycles
  task reset_dut(input logic [7:0] v, input logic p);
    @(posedge clk);
    nv_sec <= v;
    pin <= p;
    rst <= 1'b1;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    #1;
  endtask

  // Reset value, field readback, busy bit not writable
  task test_ctrl;
    logic [1:0] sp;
    cpu.sfr_read(CTRL, rd);
    chk(rd, 8'h00);
    for (int s = 0; s < 4; s++) begin
      sp = s[1:0];
      cpu.sfr_write(CTRL, {4'h3, sp[0], sp, 1'b1});
      cpu.sfr_read(CTRL, rd);
      chk(rd, {4'h3, sp[0], sp, 1'b0});
      chk(latch_mapped, sp[0]);
      chk(code_space, sp);
    end
  endtask

  // Let the launch take hold, then wait out the idle hold, bounded
  task wait_idle;
    repeat (2) @(posedge clk);
    #1;
    n = 0;
    while (cpu_idle_req === 1'b1 && n < PROG_CYCLES + 20) begin
      @(posedge clk);
      #1;
      n++;
    end
  endtask

  // Extra row lands at the top row; security space rewrites the upper nibble
  task test_spaces;
    cpu.sfr_write(CTRL, 8'h0a);
    cpu.xdata_write(16'hff83, 8'h77);
    n_er = 0;
    n_wr = 0;
    cpu.sfr_write(CTRL, 8'h52);
    cpu.sfr_write(CTRL, 8'ha2);
    wait_idle();
    chk(16'(n), 16'(PROG_CYCLES - 1));
    chk(16'(n_er), 16'd1);
    chk(16'(n_wr), 16'd1);
    chk(last_wa, 16'hff83);
    chk(last_wd, 8'h77);
    cpu.sfr_write(CTRL, 8'h0c);
    cpu.xdata_write(16'h0000, 8'h4f);
    n_wr = 0;
    cpu.sfr_write(CTRL, 8'h54);
    cpu.sfr_write(CTRL, 8'ha4);
    wait_idle();
    chk(16'(n_wr), 16'd0);
    chk(dsm, 1'b1);
    chk(boot_addr, fpc_pkg::FPC_BOOT_APP);
    chk(osc_bad, 1'b1);
    chk(security_level, 3'h1);
  endtask

  // Load two bytes, launch, try to clear busy, watch both passes
  task test_launch;
    cpu.sfr_write(CTRL, 8'h08);
    cpu.xdata_write(16'h0105, 8'h3c);
    cpu.xdata_write(16'h0106, 8'h5a);
    n_er = 0;
    n_wr = 0;
    cpu.sfr_write(CTRL, 8'h50);
    cpu.sfr_write(CTRL, 8'ha0);
    repeat (2) @(posedge clk);
    #1;
    chk(cpu_idle_req, 1'b1);
    cpu.sfr_write(CTRL, 8'h00);
    cpu.sfr_read(CTRL, rd);
    chk(rd, 8'h01);
    n = 0;
    while (cpu_idle_req === 1'b1 && n < PROG_CYCLES + 20) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk(n >= PROG_CYCLES - 12 && n <= PROG_CYCLES, 1'b1);
    chk(16'(n_er), 16'd2);
    chk(16'(n_wr), 16'd2);
    chk(last_wa, 16'h0106);
    chk(last_wd, 8'h5a);
    cpu.sfr_read(CTRL, rd);
    chk(rd[0], 1'b0);
  endtask

  // Broken unlock and reserved space must not start programming
  task test_no_launch;
    cpu.sfr_write(CTRL, 8'h50);
    cpu.sfr_write(CTRL, 8'h00);
    cpu.sfr_write(CTRL, 8'ha0);
    repeat (4) @(posedge clk);
    #1;
    chk(cpu_idle_req, 1'b0);
    cpu.sfr_write(CTRL, 8'h56);
    cpu.sfr_write(CTRL, 8'ha6);
    repeat (4) @(posedge clk);
    #1;
    chk(cpu_idle_req, 1'b0);
  endtask

  // Pin follows live at level 1, latched at level 2
  task test_pins;
    reset_dut(8'hf7, 1'b1);
    @(posedge clk);
    pin <= 1'b0;
    repeat (4) @(posedge clk);
    #1;
    chk(ice, 1'b0);
    reset_dut(8'h26, 1'b1);
    @(posedge clk);
    pin <= 1'b0;
    code_table_read <= 1'b1;
    repeat (4) @(posedge clk);
    #1;
    chk(ice, 1'b1);
    chk(trb, 1'b1);
    @(posedge clk);
    code_table_read <= 1'b0;
  endtask

  // Decode of the stored security byte
  task test_security;
    logic [7:0] v;
    logic [2:0] lvl;
    for (int i = 0; i < 5; i++) begin
      v = SEC_TBL[i];
      reset_dut(v, 1'b1);
      lvl = !v[2] ? 3'h4 : !v[1] ? 3'h3 : !v[0] ? 3'h2 : 3'h1;
      chk(dsm, !v[7]);
      chk(boot_addr, v[6] ? fpc_pkg::FPC_BOOT_APP : fpc_pkg::FPC_BOOT_LOADER);
      chk(osc_range, v[5:4]);
      chk(osc_bad, v[5:4] == 2'h0);
      chk(security_level, lvl);
      chk(ppd, lvl >= 3'h2);
      chk(pvd, lvl >= 3'h3);
      chk(eed, lvl == 3'h4);
    end
  endtask

  task tally_and_finish;
    $display("checks %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  initial begin
    reset_dut(8'hf7, 1'b1);
    test_ctrl();
    test_launch();
    test_no_launch();
    test_spaces();
    test_pins();
    test_security();
    tally_and_finish();
  end
endmodule

bind fpc_top fpc_top_properties #(.PROG_CYCLES(PROG_CYCLES)) u_props (.clk(clk),
  .rst(rst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata),
  .code_table_read_from_ext(code_table_read_from_ext), .cpu_idle_req(cpu_idle_req), .arr_erase(arr_erase),
  .arr_write(arr_write), .osc_range(osc_range), .osc_forbidden(osc_forbidden),
  .security_level(security_level), .table_read_block(table_read_block),
  .parallel_prog_disable(parallel_prog_disable),
  .parallel_verify_disable(parallel_verify_disable),
  .external_exec_disable(external_exec_disable));
